// ===== logic/serial_port.sv
// Serial port control, status, transmitter and receiver with an 8-bit control register
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`include "serial_port_regs.svh"

module serial_port
	import serial_port_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic rxd_in,
	output logic txd_out,
	output logic shift_clk_out,
	output logic irq_out
);
	import serial_port_pkg::*;

	logic [7:0] ctrl_r;
	logic fe_r;
	logic [1:0] access_r;
	logic [15:0] baud_div_r;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_en_r;
	logic [7:0] rdata_r;
	logic [7:0] rx_data_r;
	logic [2:0] rxd_sync_r;
	logic rxd_stable_r;
	mode_type mode;
	logic async_mode;
	logic nine_bit;
	logic fe_sel;
	logic wr_ctrl;
	logic tx_done_set;
	logic rx_done_set;
	logic fe_set;
	logic rx_ninth_load;
	logic rx_ninth_val;
	logic rx_byte_load;
	logic [7:0] rx_byte_val;
	logic tx_start;

	serial_tick_if tick_bus ();

	// Index of the last data bit; the ninth bit only counts in async frames
	function automatic logic [3:0] last_bit(input logic ninth);
		return ninth ? 4'h8 : 4'h7;
	endfunction

	assign mode = mode_type'(ctrl_r[`BIT_FE_OR_MODE_HIGH:`BIT_MODE_LOW]);
	assign async_mode = (mode != MODE_SHIFT);
	assign nine_bit = ctrl_r[`BIT_FE_OR_MODE_HIGH];
	assign fe_sel = access_r[`BIT_FE_SELECT];
	assign wr_ctrl = wr_in && addr_in == `ADDR_SERIAL_CONTROL;
	assign tx_start = wr_in && addr_in == `ADDR_TX_DATA;

	serial_bit_rate rate_gen (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.mode_in(mode),
		.double_speed_in(access_r[`BIT_DOUBLE_SPEED]),
		.var_div_in(baud_div_r),
		.tick(tick_bus.source)
	);

	// Receive line: three stages, change accepted when the last two agree
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			rxd_sync_r <= 3'h7;
		else
			rxd_sync_r <= {rxd_sync_r[1:0], rxd_in};
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			rxd_stable_r <= 1'b1;
		else if (rxd_sync_r[1] == rxd_sync_r[2])
			rxd_stable_r <= rxd_sync_r[2];
	end

	// Control register; hardware sets win over software writes in the same cycle
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			ctrl_r <= `SERIAL_CONTROL_RESET;
		else
		begin
			if (wr_ctrl)
			begin
				ctrl_r[6:3] <= wdata_in[6:3];
				ctrl_r[`BIT_RX_NINTH] <= wdata_in[`BIT_RX_NINTH];
				ctrl_r[`BIT_TX_DONE] <= wdata_in[`BIT_TX_DONE];
				ctrl_r[`BIT_RX_DONE] <= wdata_in[`BIT_RX_DONE];
				if (!fe_sel)
					ctrl_r[`BIT_FE_OR_MODE_HIGH] <= wdata_in[`BIT_FE_OR_MODE_HIGH];
			end
			if (rx_ninth_load)
				ctrl_r[`BIT_RX_NINTH] <= rx_ninth_val;
			if (tx_done_set)
				ctrl_r[`BIT_TX_DONE] <= 1'b1;
			if (rx_done_set)
				ctrl_r[`BIT_RX_DONE] <= 1'b1;
		end
	end

	// Framing error: only a write of zero through the error view clears it
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			fe_r <= 1'b0;
		else if (fe_set)
			fe_r <= 1'b1;
		else if (wr_ctrl && fe_sel && !wdata_in[`BIT_FE_OR_MODE_HIGH])
			fe_r <= 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			access_r <= 2'h0;
			baud_div_r <= `BAUD_DIV_RESET;
			irq_en_r <= 3'h0;
		end
		else if (wr_in)
		begin
			if (addr_in == `ADDR_ACCESS_CTRL)
				access_r <= wdata_in[1:0];
			if (addr_in == `ADDR_BAUD_DIV)
				baud_div_r <= {8'h00, wdata_in};
			if (addr_in == `ADDR_IRQ_ENABLE)
				irq_en_r <= wdata_in[2:0];
		end
	end

	// Sticky event status; a set in the clearing cycle survives
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			irq_stat_r <= 3'h0;
		else
			irq_stat_r <= (irq_stat_r & ~((wr_in && addr_in == `ADDR_IRQ_CLEAR) ?
				wdata_in[2:0] : 3'h0)) | {fe_set, rx_done_set, tx_done_set};
	end

	assign irq_out = |(irq_stat_r & irq_en_r);

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			rx_data_r <= 8'h00;
		else if (rx_byte_load)
			rx_data_r <= rx_byte_val;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			rdata_r <= 8'h00;
		else if (rd_in)
		begin
			case (addr_in)
				`ADDR_SERIAL_CONTROL: rdata_r <= {fe_sel ? fe_r : ctrl_r[7], ctrl_r[6:0]};
				`ADDR_RX_DATA: rdata_r <= rx_data_r;
				`ADDR_ACCESS_CTRL: rdata_r <= {6'h00, access_r};
				`ADDR_IRQ_STATUS: rdata_r <= {5'h00, irq_stat_r};
				`ADDR_IRQ_ENABLE: rdata_r <= {5'h00, irq_en_r};
				`ADDR_BAUD_DIV: rdata_r <= baud_div_r[7:0];
				default: rdata_r <= 8'h00;
			endcase
		end
		else
			rdata_r <= 8'h00;
	end

	assign rdata_out = rdata_r;

	// Transmitter
	tx_state_type tx_state_r;
	logic [8:0] tx_shift_r;
	logic [3:0] tx_cnt_r;
	logic txd_r;
	logic tx_pend_r;

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			tx_state_r <= TX_IDLE;
			tx_shift_r <= 9'h000;
			tx_cnt_r <= 4'h0;
			txd_r <= 1'b1;
			tx_pend_r <= 1'b0;
		end
		else
		begin
			if (tx_start && tx_state_r == TX_IDLE)
			begin
				tx_pend_r <= 1'b1;
				tx_shift_r <= {ctrl_r[`BIT_TX_NINTH], wdata_in};
			end
			if (tick_bus.bit_tick)
			begin
				case (tx_state_r)
					TX_IDLE:
						if (tx_pend_r)
						begin
							tx_pend_r <= 1'b0;
							tx_cnt_r <= 4'h0;
							txd_r <= async_mode ? 1'b0 : tx_shift_r[0];
							tx_state_r <= async_mode ? TX_START : TX_DATA;
							if (!async_mode)
								tx_shift_r <= {1'b0, tx_shift_r[8:1]};
						end
					TX_START:
					begin
						txd_r <= tx_shift_r[0];
						tx_shift_r <= {1'b0, tx_shift_r[8:1]};
						tx_state_r <= TX_DATA;
					end
					TX_DATA:
						if (tx_cnt_r == last_bit(nine_bit && async_mode))
						begin
							txd_r <= 1'b1;
							tx_state_r <= async_mode ? TX_STOP : TX_IDLE;
						end
						else
						begin
							tx_cnt_r <= tx_cnt_r + 4'h1;
							txd_r <= tx_shift_r[0];
							tx_shift_r <= {1'b0, tx_shift_r[8:1]};
						end
					TX_STOP: tx_state_r <= TX_IDLE;
					default: tx_state_r <= TX_IDLE;
				endcase
			end
		end
	end

	// Mode 0 flags at the end of bit eight; async modes as the stop bit begins
	assign tx_done_set = tick_bus.bit_tick && tx_state_r == TX_DATA &&
		tx_cnt_r == last_bit(nine_bit && async_mode);
	assign txd_out = txd_r;
	assign shift_clk_out = (mode == MODE_SHIFT) && tx_state_r == TX_DATA &&
		!tick_bus.bit_tick;

	// Receiver samples one tick after each edge; mid-bit sampling is traded for sharing one grid
	rx_state_type rx_state_r;
	logic [8:0] rx_shift_r;
	logic [3:0] rx_cnt_r;
	logic rx_last;
	logic accept;

	assign rx_last = rx_cnt_r == last_bit(nine_bit);
	// Filter: drop frames whose ninth or stop bit is zero when multiproc enabled
	assign accept = !(ctrl_r[`BIT_MULTIPROC] && async_mode) ||
		(nine_bit ? rx_shift_r[8] : rxd_stable_r);

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			rx_state_r <= RX_IDLE;
			rx_shift_r <= 9'h000;
			rx_cnt_r <= 4'h0;
		end
		else if (tick_bus.bit_tick)
		begin
			case (rx_state_r)
				RX_IDLE:
					if (ctrl_r[`BIT_RX_ENABLE] && (!async_mode || !rxd_stable_r))
					begin
						rx_cnt_r <= 4'h0;
						rx_state_r <= RX_DATA;
					end
				RX_DATA:
				begin
					rx_shift_r <= nine_bit ? {rxd_stable_r, rx_shift_r[8:1]} :
						{1'b0, rxd_stable_r, rx_shift_r[7:1]};
					rx_cnt_r <= rx_cnt_r + 4'h1;
					if (rx_last)
						rx_state_r <= async_mode ? RX_STOP : RX_IDLE;
				end
				RX_STOP: rx_state_r <= RX_IDLE;
				default: rx_state_r <= RX_IDLE;
			endcase
		end
	end

	logic at_stop;
	logic at_last_data;
	assign at_stop = tick_bus.bit_tick && rx_state_r == RX_STOP;
	assign at_last_data = tick_bus.bit_tick && rx_state_r == RX_DATA && rx_last;

	assign fe_set = at_stop && fe_sel && async_mode && !rxd_stable_r;
	assign rx_byte_load = (!async_mode && at_last_data) || (at_stop && accept);
	assign rx_byte_val = async_mode ? rx_shift_r[7:0] : {rxd_stable_r, rx_shift_r[7:1]};
	// In async modes, receive done waits for the stop bit
	assign rx_done_set = async_mode ?
		(at_stop && accept) : at_last_data;
	assign rx_ninth_load = at_stop && accept;
	assign rx_ninth_val = nine_bit ? rx_shift_r[8] : rxd_stable_r;
endmodule

// ===== logic/serial_port_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

`define ADDR_SERIAL_CONTROL 4'h0
`define ADDR_TX_DATA 4'h1
`define ADDR_RX_DATA 4'h2
`define ADDR_ACCESS_CTRL 4'h3
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_ENABLE 4'h5
`define ADDR_IRQ_CLEAR 4'h6
`define ADDR_BAUD_DIV 4'h7

`define BIT_FE_OR_MODE_HIGH 7
`define BIT_MODE_LOW 6
`define BIT_MULTIPROC 5
`define BIT_RX_ENABLE 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0

`define BIT_FE_SELECT 0
`define BIT_DOUBLE_SPEED 1

`define IRQ_TX_DONE 0
`define IRQ_RX_DONE 1
`define IRQ_FRAME_ERR 2

`define SERIAL_CONTROL_RESET 8'h00
`define BAUD_DIV_RESET 16'h001A
`define OSC_DIV_MODE0 16'h000C
`define OSC_DIV_MODE0_X2 16'h0006
`define OSC_DIV_MODE2 16'h0040
`define OSC_DIV_MODE2_X2 16'h0020

`endif

// ===== logic/serial_port_pkg.sv
// Types shared by the serial port modules
package serial_port_pkg;
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'h0,
		MODE_UART8 = 2'h1,
		MODE_UART9_FIXED = 2'h2,
		MODE_UART9_VAR = 2'h3
	} mode_type;

	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} rx_state_type;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} tx_state_type;
endpackage

// ===== logic/serial_tick_if.sv
// Bit-rate tick bundle passed from the rate generator to the serial port core
`timescale 1ns/10ps
interface serial_tick_if;
	logic bit_tick;
	modport source (output bit_tick);
	modport sink (input bit_tick);
endinterface

// ===== logic/serial_bit_rate.sv
// Bit-rate generator: cycles per bit chosen by mode, with the speed setting in modes 0 and 2 and the divider in modes 1 and 3
`timescale 1ns/10ps
`include "serial_port_regs.svh"
module serial_bit_rate
	import serial_port_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input serial_port_pkg::mode_type mode_in,
	input wire logic double_speed_in,
	input wire logic [15:0] var_div_in,
	serial_tick_if.source tick
);
	logic [15:0] count_r;
	logic [15:0] period;

	always_comb
	begin
		case (mode_in)
			MODE_SHIFT: period = double_speed_in ? `OSC_DIV_MODE0_X2 : `OSC_DIV_MODE0;
			MODE_UART9_FIXED: period = double_speed_in ? `OSC_DIV_MODE2_X2 : `OSC_DIV_MODE2;
			default: period = (var_div_in == 16'h0000) ? 16'h0001 : var_div_in;
		endcase
	end

	// Free-running so both directions share one bit grid
	always_ff @(posedge mclk_in)
	begin
		if (reset_in || count_r >= period - 16'h0001)
			count_r <= 16'h0000;
		else
			count_r <= count_r + 16'h0001;
	end

	assign tick.bit_tick = (count_r == 16'h0000);
endmodule

// ===== bench/serial_port_chk.sv
// Port-level assertions for the serial port
`timescale 1ns/10ps
module serial_port_chk (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic txd_out,
	input wire logic shift_clk_out,
	input wire logic irq_out
);
	logic sel_r;
	logic mh_r;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);
	// Shadow of the bit 7 routing, so reads can be judged without internals
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			sel_r <= 1'b0;
		else if (wr_in && addr_in == 4'h3)
			sel_r <= wdata_in[0];
	end
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
			mh_r <= 1'b0;
		else if (wr_in && addr_in == 4'h0 && !sel_r)
			mh_r <= wdata_in[7];
	end
	AST_RESET_OUT: assert property (disable iff (1'b0) reset_in |=> txd_out && !irq_out
		&& rdata_out == 8'h00 && !shift_clk_out) else $error("outputs not quiet after reset");
	AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside read answer");
	AST_UNMAPPED: assert property (rd_in && addr_in[3] |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	AST_READBACK: assert property (rd_in && addr_in == 4'h0 && $past(wr_in, 2)
		&& $past(addr_in, 2) == 4'h0 && !$past(wr_in)
		|=> (rdata_out & 8'h78) == ($past(wdata_in, 3) & 8'h78)) else $error("control readback");
	AST_TX_STICKY: assert property (rd_in && addr_in == 4'h4 ##1 rdata_out[0] && !wr_in
		##1 rd_in && addr_in == 4'h4 |=> rdata_out[0]) else $error("tx done lost");
	AST_FE_STICKY: assert property (rd_in && addr_in == 4'h4 ##1 rdata_out[2] && !wr_in
		##1 rd_in && addr_in == 4'h4 |=> rdata_out[2]) else $error("framing error lost");
	AST_IRQ_MASKED: assert property (wr_in && addr_in == 4'h5 && wdata_in == 8'h00
		|=> !irq_out) else $error("irq while masked");
	AST_BIT7_MODE: assert property (rd_in && addr_in == 4'h0 && !sel_r
		|=> rdata_out[7] == $past(mh_r)) else $error("bit 7 not mode");
endmodule
bind serial_port serial_port_chk chk (.mclk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.rdata_out, .txd_out, .shift_clk_out, .irq_out);

// ===== bench/remote_node.sv
// Remote serial node on the far side of the line
`timescale 1ns/10ps
module remote_node (
	input wire logic mclk_in,
	input wire logic line_in,
	input wire logic shift_in,
	output logic line_out
);
	int bit_cycles = 8;
	initial line_out = 1'b1;
	// A zero stop bit lets the bench provoke framing errors
	task automatic send(input logic [8:0] d, input int nb, input logic stop);
		line_out <= 1'b0;
		repeat (bit_cycles) @(posedge mclk_in);
		for (int i = 0; i < nb; i++)
		begin
			line_out <= d[i];
			repeat (bit_cycles) @(posedge mclk_in);
		end
		line_out <= stop;
		repeat (bit_cycles) @(posedge mclk_in);
		line_out <= 1'b1;
		repeat (bit_cycles) @(posedge mclk_in);
	endtask
	// Shift mode: each bit stands on the line while the shift clock is high
	task automatic recv_shift(output logic [7:0] d);
		int n;
		n = 0;
		d = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			while (shift_in !== 1'b1 && n < 4000)
			begin
				@(posedge mclk_in);
				n++;
			end
			d[i] = line_in;
			while (shift_in !== 1'b0 && n < 4000)
			begin
				@(posedge mclk_in);
				n++;
			end
		end
	endtask
	// Returns in mid stop bit
	task automatic recv(input int nb, output logic [8:0] d);
		int n;
		n = 0;
		d = 9'h000;
		while (line_in !== 1'b0 && n < 4000)
		begin
			@(posedge mclk_in);
			n++;
		end
		repeat (bit_cycles + bit_cycles / 2) @(posedge mclk_in);
		for (int i = 0; i < nb; i++)
		begin
			d[i] = line_in;
			repeat (bit_cycles) @(posedge mclk_in);
		end
	endtask
endmodule

// ===== bench/test_serial_port_control_status.sv
// Self-checking bench for the serial port control and status logic
`timescale 1ns/10ps
module test_serial_port_control_status;
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] rdata_out;
	logic rxd_in;
	logic txd_out;
	logic shift_clk_out;
	logic irq_out;
	int n_fail = 0;
	int tests_run = 0;
	logic [7:0] v;
	logic [7:0] d;
	logic [8:0] got;
	always #10 mclk_in = ~mclk_in;
	serial_port dut (.mclk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.rxd_in, .txd_out, .shift_clk_out, .irq_out);
	remote_node node (.mclk_in, .line_in(txd_out), .shift_in(shift_clk_out), .line_out(rxd_in));
	function automatic logic [7:0] exp_ctrl(input logic [1:0] m, input logic ren, input logic t8);
		return {m, 1'b0, ren, t8, 3'b000};
	endfunction
	// A gap cycle after each write keeps strobes from being reassigned in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		addr_in <= a;
		wdata_in <= x;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] x);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		// Read data stand for this one cycle; take them away from the edges
		@(negedge mclk_in);
		x = rdata_out;
		@(posedge mclk_in);
	endtask
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_out !== 1'b1 && n < 3000)
		begin
			@(posedge mclk_in);
			n++;
		end
	endtask
	task automatic conclude;
		$display("Counts: %0d compared, %0d failed", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge mclk_in);
		n_fail++;
		conclude();
	end
	initial
	begin
		void'($urandom(32'h6BC46287));
		repeat (10) @(posedge mclk_in);
		reset_in <= 1'b0;
		@(posedge mclk_in);
		rd(4'h0, v);
		chk(v, 8'h00);
		rd(4'h9, v);
		chk(v, 8'h00);
		$display("Test reset done");
		wr(4'h7, 8'h08);
		wr(4'h5, 8'h07);
		wr(4'h0, exp_ctrl(2'h1, 1'b1, 1'b0));
		rd(4'h0, v);
		chk(v, 8'h50);
		d = 8'($urandom);
		wr(4'h1, d);
		chk(irq_out, 1'b0);
		node.recv(8, got);
		chk(got[7:0], d);
		chk(irq_out, 1'b1);
		rd(4'h4, v);
		rd(4'h4, v);
		chk(v[0], 1'b1);
		rd(4'h0, v);
		chk(v[1], 1'b1);
		wr(4'h0, 8'h50);
		wr(4'h6, 8'h07);
		rd(4'h0, v);
		chk(v[1], 1'b0);
		repeat (16) @(posedge mclk_in);
		$display("Test transmit done");
		wr(4'h3, 8'h01);
		d = 8'($urandom);
		node.send(d, 8, 1'b0);
		wait_irq();
		rd(4'h0, v);
		chk(v[7], 1'b1);
		chk(v[0], 1'b1);
		rd(4'h2, v);
		chk(v, d);
		rd(4'h4, v);
		rd(4'h4, v);
		chk(v[2], 1'b1);
		wr(4'h6, 8'h07);
		node.send(~d, 8, 1'b1);
		wait_irq();
		rd(4'h0, v);
		chk(v[7], 1'b1);
		chk(v[2], 1'b1);
		wr(4'h0, 8'h50);
		rd(4'h0, v);
		chk(v[7], 1'b0);
		$display("Test framing done");
		wr(4'h0, 8'h40);
		wr(4'h6, 8'h07);
		node.send(9'($urandom), 8, 1'b1);
		repeat (40) @(posedge mclk_in);
		chk(irq_out, 1'b0);
		$display("Test receive gate done");
		wr(4'h3, 8'h00);
		for (int m = 2; m < 4; m++)
		begin
			node.bit_cycles = (m == 2) ? 64 : 8;
			v = exp_ctrl(m[1:0], 1'b1, m[0]);
			wr(4'h0, v);
			wr(4'h6, 8'h07);
			rd(4'h0, d);
			chk(d & 8'hF8, v);
			d = 8'($urandom);
			wr(4'h1, d);
			node.recv(9, got);
			chk(got, {v[3], d});
			repeat (2 * node.bit_cycles) @(posedge mclk_in);
			wr(4'h6, 8'h07);
			node.send({~m[0], d}, 9, 1'b1);
			wait_irq();
			rd(4'h0, d);
			chk(d[2], !m[0]);
		end
		$display("Test ninth bit done");
		wr(4'h0, 8'hF0);
		wr(4'h6, 8'h07);
		d = 8'($urandom);
		node.send({1'b0, d}, 9, 1'b1);
		repeat (16) @(posedge mclk_in);
		chk(irq_out, 1'b0);
		node.send({1'b1, d ^ 8'hFF}, 9, 1'b1);
		wait_irq();
		rd(4'h2, v);
		chk(v, d ^ 8'hFF);
		$display("Test multiproc done");
		// Shift mode with the receiver off and the filter bit clear
		wr(4'h0, 8'h00);
		wr(4'h6, 8'h07);
		d = 8'($urandom);
		wr(4'h1, d);
		node.recv_shift(v);
		chk(v, d);
		repeat (4) @(posedge mclk_in);
		rd(4'h4, v);
		chk(v, 8'h01);
		$display("Test shift mode done");
		wr(4'h5, 8'h00);
		conclude();
	end
endmodule
